// ---- rtl/gpc_top.sv ----
`timescale 1ns/10ps
module gpc_top
    import gpc_pkg::*;
(
    input  wire logic             clock,      // 100 MHz clock
    input  wire logic             rstn,       // async reset, active low
    input  wire logic             psel,       // apb select
    input  wire logic             penable,    // apb enable
    input  wire logic             pwrite,     // apb direction
    input  wire logic [11:0]      paddr,      // apb byte address
    input  wire logic [31:0]      pwdata,     // apb write data
    output logic      [31:0]      prdata,     // apb read data
    output logic                  pready,     // apb ready
    output logic                  pslverr,    // apb error
    input  wire logic [NPIN-1:0]  pin_i,      // pad input levels
    output gpc_pad_t              pad,        // pad output and enable
    input  wire gpc_alt_t         alt_in,     // alternate function drive
    output logic [NPIN-1:0]       alt_out,    // polarity-adjusted pad level to peripherals
    output logic [NPIN-1:0]       alt_sel,    // pin in function 00
    output logic [NPIN-1:0]       irq_sel,    // pin routed to its host irq
    output logic [NPIN-1:0]       ext_sel,    // pin in function 11, except pin 6.5
    output logic [NPIN-1:0]       edge_irq,   // either-edge interrupt pulses
    output logic [15:0]           host_irq,   // group interrupt on host lines
    output logic                  grp_irq     // group interrupt level
);
    logic [CFG_W-1:0] cfg_reg  [NPIN];
    logic [CFG_W-1:0] cfg_next [NPIN];
    logic [CFG_W-1:0] gi2_reg, gi2_next;
    logic [NPIN-1:0]  dat_reg, dat_next;
    logic [NPIN-1:0]  pin_reg, pin_next;
    logic [NPIN-1:0]  sense;
    logic             wr_stb, rd_stb, grp_raw, grp_filt;
    logic [7:0]       idx;
    logic [3:0]       pidx;
    logic             hit_cfg;
    logic [31:0]      rdata_next, rdata_reg;
    logic             err_next, err_reg;
    gpc_pad_t         pad_next, pad_reg;
    logic [NPIN-1:0]  aout_next, aout_reg, asel_next, asel_reg;
    logic [NPIN-1:0]  isel_next, isel_reg, xsel_next, xsel_reg;
    logic [NPIN-1:0]  edge_next, edge_reg;
    logic [15:0]      hirq_next, hirq_reg;
    logic             girq_reg;

    // index to config slot; NPIN means no hit
    function automatic logic [3:0] slot(input logic [7:0] i);
        if (i == IDX_P53) begin
            return 4'd0;
        end else if (i == IDX_P54) begin
            return 4'd1;
        end else if (i >= IDX_P60 && i <= IDX_P66) begin
            return 4'(i - IDX_P60) + 4'd2;
        end else begin
            return 4'(NPIN);
        end
    endfunction

    gpc_apb_slave u_apb (
        .clock   (clock),
        .rstn    (rstn),
        .psel    (psel),
        .penable (penable),
        .pready  (pready),
        .wr_stb  (wr_stb),
        .rd_stb  (rd_stb)
    );

    gpc_debounce u_deb (
        .clock (clock),
        .rstn  (rstn),
        .din   (grp_raw),
        .dout  (grp_filt)
    );

    assign idx     = paddr[9:2];
    assign pidx    = slot(idx);
    assign hit_cfg = (pidx != 4'(NPIN)) && (paddr[1:0] == 2'b00);

    // polarity-adjusted sense of each pad
    always_comb begin
        for (int p = 0; p < NPIN; p++) begin
            sense[p] = pin_reg[p] ^ cfg_reg[p][B_POL];
        end
    end

    // register writes
    always_comb begin
        for (int p = 0; p < NPIN; p++) begin
            cfg_next[p] = cfg_reg[p];
        end
        gi2_next = gi2_reg;
        dat_next = dat_reg;
        if (wr_stb && pwrite) begin
            if (hit_cfg) begin
                cfg_next[pidx] = pwdata[CFG_W-1:0];
            end else if (paddr == gpc_addr(IDX_GI2)) begin
                gi2_next = pwdata[CFG_W-1:0] & GI2_WMASK;
            end else if (paddr == gpc_addr(IDX_DATA)) begin
                dat_next = pwdata[NPIN-1:0];
            end
        end
    end

    // register reads; unmapped gives zero and slave error
    always_comb begin
        rdata_next = rdata_reg;
        err_next   = 1'b0;
        if (rd_stb && !pwrite) begin
            rdata_next = '0;
            if (hit_cfg) begin
                rdata_next[CFG_W-1:0] = cfg_reg[pidx];
            end else if (paddr == gpc_addr(IDX_GI2)) begin
                rdata_next[CFG_W-1:0] = gi2_reg;
            end else if (paddr == gpc_addr(IDX_DATA)) begin
                rdata_next[NPIN-1:0] = dat_reg;
            end else if (paddr == gpc_addr(IDX_PIN)) begin
                rdata_next[NPIN-1:0] = sense;
            end else if (paddr == gpc_addr(IDX_GST)) begin
                rdata_next[0] = grp_raw;
                rdata_next[1] = girq_reg;
            end else begin
                err_next = 1'b1;
            end
        end
    end

    // pin routing and drive
    always_comb begin
        pad_next  = '0;
        aout_next = '0;
        asel_next = '0;
        isel_next = '0;
        xsel_next = '0;
        grp_raw   = 1'b0;
        for (int p = 0; p < NPIN; p++) begin
            logic [1:0] fn;
            logic       drv;
            logic       en;
            fn  = cfg_reg[p][B_FSH:B_FSL];
            drv = 1'b0;
            en  = 1'b0;
            aout_next[p] = sense[p];
            grp_raw = grp_raw | (cfg_reg[p][B_GRP] & sense[p]);
            case (fn)
                FN_GPIO: begin
                    drv = dat_reg[p] ^ cfg_reg[p][B_POL];
                    en  = !cfg_reg[p][B_DIR];
                end
                FN_ALT: begin
                    asel_next[p] = 1'b1;
                    drv = alt_in.to_pin[p] ^ cfg_reg[p][B_POL];
                    en  = alt_in.to_pin_oe[p] && !cfg_reg[p][B_DIR];
                end
                FN_IRQ: begin
                    isel_next[p] = 1'b1;
                end
                FN_EXT: begin
                    // pin 6.5 code 11 is reserved: routed nowhere
                    xsel_next[p] = (p != 7);
                    drv = alt_in.to_pin[p] ^ cfg_reg[p][B_POL];
                    en  = (p != 7) && alt_in.to_pin_oe[p] && !cfg_reg[p][B_DIR];
                end
                default: ;
            endcase
            if (cfg_reg[p][B_ODR]) begin
                pad_next.o[p]  = 1'b0;
                pad_next.oe[p] = en && !drv;
            end else begin
                pad_next.o[p]  = drv && en;
                pad_next.oe[p] = en;
            end
        end
    end

    // edge interrupts for pins 5.3 and 5.4 in function 11
    always_comb begin
        edge_next = '0;
        for (int p = 0; p < 2; p++) begin
            edge_next[p] = (cfg_reg[p][B_FSH:B_FSL] == FN_EXT) &&
                           (sense[p] != aout_reg[p]);
        end
    end

    // group interrupt to host line
    always_comb begin
        logic       lvl;
        logic [3:0] map;
        lvl = 1'b0;
        map = gi2_reg[B_MAPH:B_MAPL];
        hirq_next = '0;
        lvl = gi2_reg[B_FILT] ? grp_filt : grp_raw;
        if (map != MAP_OFF && map != MAP_BAD) begin
            hirq_next[map] = lvl;
        end
    end

    // state and output registers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int p = 0; p < NPIN; p++) begin
                cfg_reg[p] <= CFG_RST;
            end
            gi2_reg   <= GI2_RST;
            dat_reg   <= '0;
            pin_reg   <= '0;
            rdata_reg <= '0;
            err_reg   <= 1'b0;
            pad_reg   <= '0;
            aout_reg  <= '0;
            asel_reg  <= '0;
            isel_reg  <= '0;
            xsel_reg  <= '0;
            edge_reg  <= '0;
            hirq_reg  <= '0;
            girq_reg  <= 1'b0;
        end else begin
            for (int p = 0; p < NPIN; p++) begin
                cfg_reg[p] <= cfg_next[p];
            end
            gi2_reg   <= gi2_next;
            dat_reg   <= dat_next;
            pin_reg   <= pin_next;
            rdata_reg <= rdata_next;
            err_reg   <= err_next;
            pad_reg   <= pad_next;
            aout_reg  <= aout_next;
            asel_reg  <= asel_next;
            isel_reg  <= isel_next;
            xsel_reg  <= xsel_next;
            edge_reg  <= edge_next;
            hirq_reg  <= hirq_next;
            girq_reg  <= gi2_reg[B_FILT] ? grp_filt : grp_raw;
        end
    end

    assign pin_next = pin_i;
    assign prdata   = rdata_reg;
    assign pslverr  = err_reg;
    assign pad      = pad_reg;
    assign alt_out  = aout_reg;
    assign alt_sel  = asel_reg;
    assign irq_sel  = isel_reg;
    assign ext_sel  = xsel_reg;
    assign edge_irq = edge_reg;
    assign host_irq = hirq_reg;
    assign grp_irq  = girq_reg;
endmodule

// ---- rtl/gpc_pkg.sv ----
package gpc_pkg;
    // pin count and register width
    localparam int NPIN  = 9;
    localparam int CFG_W = 8;

    // register indexes (byte address is four times the index)
    localparam logic [7:0] IDX_P53  = 8'hCB;
    localparam logic [7:0] IDX_P54  = 8'hCC;
    localparam logic [7:0] IDX_P60  = 8'hD0;
    localparam logic [7:0] IDX_P61  = 8'hD1;
    localparam logic [7:0] IDX_P62  = 8'hD2;
    localparam logic [7:0] IDX_P63  = 8'hD3;
    localparam logic [7:0] IDX_P64  = 8'hD4;
    localparam logic [7:0] IDX_P65  = 8'hD5;
    localparam logic [7:0] IDX_P66  = 8'hD6;
    localparam logic [7:0] IDX_GI2  = 8'hEF;
    localparam logic [7:0] IDX_DATA = 8'hF8;
    localparam logic [7:0] IDX_PIN  = 8'hF9;
    localparam logic [7:0] IDX_GST  = 8'hFA;

    // field positions
    localparam int B_DIR  = 0;
    localparam int B_POL  = 1;
    localparam int B_FSL  = 3;
    localparam int B_FSH  = 4;
    localparam int B_GRP  = 5;
    localparam int B_ODR  = 7;
    localparam int B_FILT = 3;
    localparam int B_MAPL = 4;
    localparam int B_MAPH = 7;

    // reset values and group write mask
    localparam logic [7:0] CFG_RST = 8'h01;
    localparam logic [7:0] GI2_RST = 8'h00;
    localparam logic [7:0] GI2_WMASK = 8'hF8;

    // function select codes
    localparam logic [1:0] FN_ALT  = 2'b00;
    localparam logic [1:0] FN_IRQ  = 2'b01;
    localparam logic [1:0] FN_GPIO = 2'b10;
    localparam logic [1:0] FN_EXT  = 2'b11;

    // group irq line map
    localparam logic [3:0] MAP_OFF = 4'h0;
    localparam logic [3:0] MAP_BAD = 4'h2;

    // debounce window
    localparam int DEB_NS  = 100;
    localparam int CLK_NS  = 10;
    localparam int DEB_CYC = (DEB_NS + CLK_NS - 1) / CLK_NS;
    localparam int DEB_W   = 4;

    typedef enum logic [1:0] {GPC_IDLE, GPC_ACCESS} gpc_apb_st_t;

    // per-pin peripheral signal bundle
    typedef struct packed {
        logic [NPIN-1:0] to_pin;
        logic [NPIN-1:0] to_pin_oe;
    } gpc_alt_t;

    // pin drive bundle
    typedef struct packed {
        logic [NPIN-1:0] o;
        logic [NPIN-1:0] oe;
    } gpc_pad_t;

    // cfg word index to byte address
    function automatic logic [11:0] gpc_addr(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction
endpackage

// ---- rtl/gpc_debounce.sv ----
`timescale 1ns/10ps
module gpc_debounce
    import gpc_pkg::*;
(
    input  wire logic clock,   // system clock
    input  wire logic rstn,    // async reset
    input  wire logic din,     // raw level
    output logic      dout     // filtered level
);
    logic [DEB_W-1:0] cnt_reg, cnt_next;
    logic             out_reg, out_next;

    // level must hold DEB_CYC cycles before it passes
    always_comb begin
        cnt_next = cnt_reg;
        out_next = out_reg;
        if (din == out_reg) begin
            cnt_next = '0;
        end else if (cnt_reg == DEB_W'(DEB_CYC - 1)) begin
            cnt_next = '0;
            out_next = din;
        end else begin
            cnt_next = cnt_reg + DEB_W'(1);
        end
    end

    // state registers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= '0;
            out_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            out_reg <= out_next;
        end
    end

    assign dout = out_reg;
endmodule

// ---- rtl/gpc_apb_slave.sv ----
`timescale 1ns/10ps
module gpc_apb_slave
    import gpc_pkg::*;
(
    input  wire logic        clock,    // system clock
    input  wire logic        rstn,     // async reset
    input  wire logic        psel,     // apb select
    input  wire logic        penable,  // apb enable
    output logic             pready,   // apb ready
    output logic             wr_stb,   // one-cycle write strobe
    output logic             rd_stb    // one-cycle read strobe
);
    gpc_apb_st_t st_reg, st_next;
    logic        rdy_reg, rdy_next;

    // setup then one wait cycle, answer on second access cycle edge
    always_comb begin
        st_next  = st_reg;
        rdy_next = 1'b0;
        case (st_reg)
            GPC_IDLE: begin
                if (psel && penable && !rdy_reg) begin
                    st_next  = GPC_ACCESS;
                    rdy_next = 1'b1;
                end
            end
            GPC_ACCESS: begin
                st_next = GPC_IDLE;
            end
            default: st_next = GPC_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_reg  <= GPC_IDLE;
            rdy_reg <= 1'b0;
        end else begin
            st_reg  <= st_next;
            rdy_reg <= rdy_next;
        end
    end

    assign pready = rdy_reg;
    assign wr_stb = rdy_reg && psel && penable;
    // read data is captured on the edge that raises ready, so it stands with it
    assign rd_stb = (st_reg == GPC_IDLE) && psel && penable && !rdy_reg;
endmodule

// ---- sim/gpc_sva.sv ----
`timescale 1ns/10ps
module gpc_sva
    import gpc_pkg::*;
(
    input wire logic            clock,    // clock
    input wire logic            rstn,     // reset
    input wire logic            psel,     // select
    input wire logic            penable,  // enable
    input wire logic            pwrite,   // direction
    input wire logic [11:0]     paddr,    // address
    input wire logic [31:0]     prdata,   // read data
    input wire logic            pready,   // ready
    input wire logic            pslverr,  // error
    input wire logic [NPIN-1:0] alt_sel,  // function 00
    input wire logic [NPIN-1:0] irq_sel,  // function 01
    input wire logic [NPIN-1:0] ext_sel,  // function 11
    input wire logic [NPIN-1:0] edge_irq, // edge pulses
    input wire logic [15:0]     host_irq  // host lines
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    // bus answers after one wait state, as a single pulse
    chk_ready_answer: assert property (psel && penable && !pready |=> pready)
        else $error("ready missing after access");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    // error only on a completing read
    chk_err_read: assert property (pslverr |-> pready && !pwrite)
        else $error("error outside a read");
    chk_unmapped_read: assert property (psel && penable && !pready && !pwrite
        && paddr == 12'h000 |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    // one function per pin
    chk_sel_exclusive: assert property ((alt_sel & irq_sel) == 0
        && (irq_sel & ext_sel) == 0 && (alt_sel & ext_sel) == 0)
        else $error("pin in two functions");
    // edge interrupts exist on two pins only
    chk_edge_pins: assert property (edge_irq[NPIN-1:2] == 0)
        else $error("edge pulse on wrong pin");
    chk_edge_cause: assert property (edge_irq[1:0] != 0 |->
        (edge_irq[1:0] & ~(ext_sel[1:0] | $past(ext_sel[1:0]))) == 0)
        else $error("edge pulse outside function 11");
    // at most one host line, never 0 or the invalid 2
    chk_host_map: assert property ($onehot0(host_irq) && !host_irq[0] && !host_irq[2])
        else $error("bad host line");
endmodule

bind gpc_top gpc_sva u_sva (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alt_sel(alt_sel), .irq_sel(irq_sel), .ext_sel(ext_sel), .edge_irq(edge_irq),
    .host_irq(host_irq));

// ---- sim/gpc_board.sv ----
`timescale 1ns/10ps
module gpc_board
    import gpc_pkg::*;
(
    input  wire gpc_pad_t        pad,     // device drive
    input  wire logic [NPIN-1:0] ext_oe,  // board drives line
    input  wire logic [NPIN-1:0] ext_val, // board level
    output logic      [NPIN-1:0] pin_i    // line level
);
    // device first, then board, else pull-up
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            if (pad.oe[i]) begin
                pin_i[i] = pad.o[i];
            end else if (ext_oe[i]) begin
                pin_i[i] = ext_val[i];
            end else begin
                pin_i[i] = 1'b1;
            end
        end
    end
endmodule

// ---- sim/gpc_top_test.sv ----
`timescale 1ns/10ps
module gpc_top_test;
    import gpc_pkg::*;
    logic            clock, rstn, psel, penable, pwrite, pready, pslverr, grp_irq, err, g;
    logic [11:0]     paddr;
    logic [31:0]     pwdata, prdata, rd;
    logic [NPIN-1:0] pin_i, alt_out, alt_sel, irq_sel, ext_sel, edge_irq;
    logic [NPIN-1:0] ext_oe, ext_val, m, pol, en, adj;
    logic [15:0]     host_irq;
    gpc_pad_t        pad;
    gpc_alt_t        alt_in;
    logic [7:0]      idx [NPIN];
    logic [7:0]      cfg [NPIN];
    logic [3:0]      maps [5];
    int              seed, err_count, check_count, k;

    gpc_top u_dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_i(pin_i), .pad(pad), .alt_in(alt_in), .alt_out(alt_out),
        .alt_sel(alt_sel), .irq_sel(irq_sel), .ext_sel(ext_sel), .edge_irq(edge_irq),
        .host_irq(host_irq), .grp_irq(grp_irq));
    gpc_board u_board (.pad(pad), .ext_oe(ext_oe), .ext_val(ext_val), .pin_i(pin_i));

    // clock
    always #5 clock = ~clock;

    // compare and count
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // counts and verdict
    task automatic test_done();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // one bus transfer after an idle cycle
    task automatic apb(input logic wr, input logic [7:0] ix, input logic [31:0] wd);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, ix, 2'b00};
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        // sample ready at rising edges only; request held until then
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            err_count++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // let pin and register pipelines land
    task automatic settle();
        repeat (4) @(posedge clock);
        @(negedge clock);
    endtask

    // expected {oe, o} of a pin
    function automatic logic [1:0] exp_drive(input logic [7:0] c, input logic d);
        logic v;
        v = d ^ c[B_POL];
        if (c[B_DIR] || c[4:3] != FN_GPIO) return 2'b00;
        return c[B_ODR] ? {~v, 1'b0} : {1'b1, v};
    endfunction

    initial begin
        clock = 1'b0;
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        alt_in = '0;
        ext_oe = '0;
        ext_val = '0;
        seed = 95769;
        err_count = 0;
        check_count = 0;
        idx = '{IDX_P53, IDX_P54, IDX_P60, IDX_P61, IDX_P62, IDX_P63, IDX_P64, IDX_P65, IDX_P66};
        maps = '{4'h3, 4'hF, 4'h2, 4'h0, 4'h1};
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        chk("oe in reset", 32'(pad.oe), 32'h0000_0000);
        // reset values, unmapped place
        for (int i = 0; i < NPIN; i++) begin
            apb(1'b0, idx[i], 32'h0000_0000);
            chk("cfg reset", rd, 32'h0000_0001);
        end
        apb(1'b0, IDX_GI2, 32'h0000_0000);
        chk("group reset", rd, 32'h0000_0000);
        apb(1'b1, 8'h00, 32'hFFFF_FFFF);
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk("unmapped data", rd, 32'h0000_0000);
        chk("unmapped err", 32'(err), 32'h0000_0001);
        // random gpio drive and readback
        repeat (6) begin
            alt_in <= 18'($random(seed));
            m = NPIN'($random(seed));
            for (int i = 0; i < NPIN; i++) begin
                cfg[i] = 8'($random(seed)) & 8'hA3 | 8'h10;
                apb(1'b1, idx[i], 32'(cfg[i]));
                apb(1'b0, idx[i], 32'h0000_0000);
                chk("cfg readback", rd, 32'(cfg[i]));
            end
            apb(1'b1, IDX_DATA, 32'(m));
            settle();
            for (int i = 0; i < NPIN; i++)
                chk("pad", 32'({pad.oe[i], pad.o[i]}), 32'(exp_drive(cfg[i], m[i])));
        end
        // input polarity and group map
        ext_oe <= '1;
        foreach (maps[j]) begin
            for (int i = 0; i < NPIN; i++) begin
                cfg[i] = 8'($random(seed)) & 8'h22 | 8'h11;
                apb(1'b1, idx[i], 32'(cfg[i]));
                pol[i] = cfg[i][B_POL];
                en[i] = cfg[i][B_GRP];
            end
            apb(1'b1, IDX_GI2, 32'({maps[j], 4'h0}));
            ext_val <= NPIN'($random(seed));
            settle();
            adj = ext_val ^ pol;
            g = |(adj & en);
            chk("alt out", 32'(alt_out), 32'(adj));
            chk("group", 32'(grp_irq), 32'(g));
            chk("host", 32'(host_irq), (maps[j] == MAP_OFF || maps[j] == MAP_BAD) ?
                32'h0000_0000 : 32'(g) << maps[j]);
            apb(1'b0, IDX_PIN, 32'h0000_0000);
            chk("pin state", rd, 32'(adj));
        end
        // debounce holds the group level back
        apb(1'b1, IDX_P53, 32'h0000_0031);
        apb(1'b1, IDX_GI2, 32'h0000_0038);
        pol[0] = 1'b0;
        ext_val <= pol;
        repeat (16) @(posedge clock);
        ext_val <= pol ^ 9'h001;
        settle();
        chk("filtered early", 32'(grp_irq), 32'h0000_0000);
        repeat (12) @(posedge clock);
        chk("filtered late", 32'(host_irq), 32'h0000_0008);
        // every function code on every pin, except code 11 on pin 6.5
        for (int c = 0; c < 4; c++) begin
            for (int i = 0; i < NPIN; i++) begin
                cfg[i] = (c == 3 && i == 7) ? 8'h11 : {3'b000, 2'(c), 3'b001};
                apb(1'b1, idx[i], 32'(cfg[i]));
            end
            settle();
            chk("alt sel", 32'(alt_sel), (c == 0) ? 32'h0000_01FF : 32'h0);
            chk("irq sel", 32'(irq_sel), (c == 1) ? 32'h0000_01FF : 32'h0);
            chk("ext sel", 32'(ext_sel), (c == 3) ? 32'h0000_017F : 32'h0);
            if (c == 3) begin
                @(posedge clock);
                ext_val <= ext_val ^ 9'h003;
                for (k = 0; k < 8 && edge_irq[1:0] !== 2'b11; k++) @(negedge clock);
                chk("edge pulse", 32'(k < 8), 32'h0000_0001);
            end
        end
        // reset in mid-run
        @(posedge clock);
        rstn <= 1'b0;
        @(posedge clock);
        rstn <= 1'b1;
        apb(1'b0, IDX_P60, 32'h0000_0000);
        chk("cfg after reset", rd, 32'h0000_0001);
        test_done();
    end
endmodule
